/* rtl/lit_file_exec.sv */
// Execute stage for or-literal, or-with-file, copy-file and load-literal.
// Assumes a register file on mclk with a combinational read port addressed
// by file_raddr and a write port taken on the edge where file_we is high.
// Other instructions are decoded elsewhere; words not recognised pass as
// no-ops here.
`timescale 1ns/1ps

module lit_file_exec (
  // Clock and reset
  input  wire logic                                mclk,
  input  wire logic                                sys_rst,
  // Instruction stream, one word per cycle at most
  input  wire logic                                instr_valid,
  input  wire logic [lit_file_ops_pkg::WORD_W-1:0] instr_word,
  // Register file read port
  output logic      [lit_file_ops_pkg::ADDR_W-1:0] file_raddr,
  input  wire logic [lit_file_ops_pkg::DATA_W-1:0] file_rdata,
  // Register file write port
  output logic                                     file_we,
  output logic      [lit_file_ops_pkg::ADDR_W-1:0] file_waddr,
  output logic      [lit_file_ops_pkg::DATA_W-1:0] file_wdata,
  // Architectural state
  output logic      [lit_file_ops_pkg::DATA_W-1:0] acc,
  output logic                                     zero_flag,
  // Completion pulse for a handled operation
  output logic                                     exec_done
);

  localparam int DW = lit_file_ops_pkg::DATA_W;
  localparam int AW = lit_file_ops_pkg::ADDR_W;

  ////////////////////////////////////////////////////////////////////////////
  // Timing of one operation
  // Edge T: word taken into the fetch fields when instr_valid is high
  // Cycle after T: fetch fields address the file, operand read and combined
  // Edge T+1: accumulator, zero flag, write port and done pulse updated
  // Edge T+2: register file takes the write, strobe and done pulse drop
  // A new word may arrive on every edge; nothing stalls or flushes
  // A read of the address written by the previous op is forwarded
  // Words outside the four patterns leave the accumulator and zero flag as they were

  // Limits a user must know
  // Bank switching and indirect addressing live outside this block
  // The read data must settle within the cycle its address is shown
  // The register file must write on the edge where file_we is high
  // Flags other than zero are neither read nor written here

  ////////////////////////////////////////////////////////////////////////////
  // State of the block
  typedef struct packed {
    logic                  s1_valid;  // Fetched word held
    lit_file_ops_pkg::op_e s1_op;     // Its decoded operation
    logic                  s1_dest;   // Its target choice bit
    logic [AW-1:0]         s1_addr;   // Its file address
    logic [DW-1:0]         s1_lit;    // Its literal byte
    logic [DW-1:0]         acc;       // Accumulator
    logic                  zero;      // Zero flag
    logic                  we;        // Pending file write
    logic [AW-1:0]         waddr;     // Pending write address
    logic [DW-1:0]         wdata;     // Pending write data
    logic                  done;      // Operation finished
  } state_s;

  state_s st_r;   // Registered state
  state_s st_nxt; // Next state

  // Decoder results for the incoming word
  lit_file_ops_pkg::op_e dec_op;    // Operation
  logic                  dec_dest;  // Target choice
  logic [AW-1:0]         dec_addr;  // File address
  logic [DW-1:0]         dec_lit;   // Literal

  // Execute-stage working values
  logic [DW-1:0]         file_val;  // File operand after forwarding
  logic [DW-1:0]         result;    // Operation result
  logic                  fwd_hit;   // Pending write hits the read

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // True when a byte is all zeros
  function automatic logic is_zero(input logic [DW-1:0] v);
    is_zero = (v == '0);
  endfunction : is_zero

  // Route a result to accumulator or file per the target bit
  function automatic logic to_file(input logic d);
    to_file = (d == lit_file_ops_pkg::DEST_FILE);
  endfunction : to_file

  ////////////////////////////////////////////////////////////////////////////
  // Opcode decoder
  // Splits the incoming word so the fetch fields hold ready operands
  lit_file_decode u_decode (
    .word (instr_word),
    .op   (dec_op),
    .dest (dec_dest),
    .addr (dec_addr),
    .lit  (dec_lit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    // Hold everything unless an operation below changes it
    st_nxt   = st_r;
    result   = st_r.acc;
    // Hazard: the previous write lands only at the end of this cycle,
    // so a read of the same address must take the pending value.
    fwd_hit  = st_r.we && (st_r.waddr == st_r.s1_addr);
    file_val = fwd_hit ? st_r.wdata : file_rdata;

    st_nxt.s1_valid = instr_valid;
    // Operation cleared when no word is offered
    st_nxt.s1_op    = instr_valid ? dec_op : lit_file_ops_pkg::OP_NONE;
    st_nxt.s1_dest  = dec_dest;
    st_nxt.s1_addr  = dec_addr;
    st_nxt.s1_lit   = dec_lit;

    // Write port and completion default to idle
    st_nxt.we    = 1'b0;
    // Address always tracks the executing word
    st_nxt.waddr = st_r.s1_addr;
    st_nxt.wdata = st_r.wdata;
    st_nxt.done  = 1'b0;

    // Execute the word latched at the previous edge
    if (st_r.s1_valid) begin
      case (st_r.s1_op)
        lit_file_ops_pkg::OP_OR_LITERAL_INTO: begin
          result = st_r.acc | st_r.s1_lit;
          st_nxt.acc  = result;
          st_nxt.zero = is_zero(result);
          st_nxt.done = 1'b1;
        end
        lit_file_ops_pkg::OP_OR_ACC_WITH_FILE: begin
          result = st_r.acc | file_val;
          if (to_file(st_r.s1_dest)) begin
            // Target bit set: back to the register
            st_nxt.we    = 1'b1;
            st_nxt.wdata = result;
          end else begin
            // Target bit clear: accumulator takes it
            st_nxt.acc = result;
          end
          st_nxt.zero = is_zero(result);
          st_nxt.done = 1'b1;
        end
        lit_file_ops_pkg::OP_COPY_FILE_VALUE: begin
          result = file_val;
          if (to_file(st_r.s1_dest)) begin
            // Same value written back, a zero test
            st_nxt.we    = 1'b1;
            st_nxt.wdata = result;
          end else begin
            // Value lands in the accumulator
            st_nxt.acc = result;
          end
          st_nxt.zero = is_zero(result);
          st_nxt.done = 1'b1;
        end
        lit_file_ops_pkg::OP_LOAD_LITERAL_ACC: begin
          result      = st_r.s1_lit;
          st_nxt.acc  = result;
          st_nxt.done = 1'b1;
        end
        default: begin
          // Not ours: no change
          result = st_r.acc;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk) begin
    // Synchronous reset, active high
    if (sys_rst) begin
      // Whole state cleared, then named reset values
      st_r          <= '0;
      st_r.s1_op    <= lit_file_ops_pkg::OP_NONE;
      st_r.acc      <= lit_file_ops_pkg::ACC_RST;
      st_r.zero     <= lit_file_ops_pkg::ZERO_RST;
    end else begin
      // Every field advances on every edge
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register
  // Read address follows the fetched word
  assign file_raddr = st_r.s1_addr;
  // Write port, one-cycle strobe
  assign file_we    = st_r.we;
  assign file_waddr = st_r.waddr;
  assign file_wdata = st_r.wdata;
  // Architectural state
  assign acc        = st_r.acc;
  assign zero_flag  = st_r.zero;
  // Completion pulse
  assign exec_done  = st_r.done;

endmodule : lit_file_exec

/* rtl/lit_file_ops_pkg.sv */
// Shared constants and the operation type for the literal/file execute block.
// Assumes a 14-bit program word, 8-bit data path and 7-bit direct file address.
package lit_file_ops_pkg;

  // Data path shapes
  localparam int WORD_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;

  // Field positions inside the program word
  localparam int OPC_MSB  = 13;
  localparam int OPC6_LSB = 8;
  localparam int OPC4_LSB = 10;
  localparam int LIT_MSB  = 7;
  localparam int LIT_LSB  = 0;
  localparam int DEST_BIT = 7;
  localparam int ADDR_MSB = 6;
  localparam int ADDR_LSB = 0;

  // Opcode patterns (upper six bits, or upper four for the load)
  localparam logic [5:0] PAT_OR_LIT    = 6'h38;
  localparam logic [5:0] PAT_OR_FILE   = 6'h04;
  localparam logic [5:0] PAT_COPY_FILE = 6'h08;
  localparam logic [3:0] PAT_LOAD_LIT  = 4'hc;

  // Target choice bit values
  localparam logic DEST_ACC  = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Reset values
  localparam logic [7:0] ACC_RST  = 8'h00;
  localparam logic       ZERO_RST = 1'b0;

  // Decoded operation
  typedef enum logic [2:0] {
    OP_NONE              = 3'h0,
    OP_OR_LITERAL_INTO   = 3'h1,
    OP_OR_ACC_WITH_FILE  = 3'h3,
    OP_COPY_FILE_VALUE   = 3'h2,
    OP_LOAD_LITERAL_ACC  = 3'h6
  } op_e;

endpackage : lit_file_ops_pkg

/* rtl/lit_file_decode.sv */
// Opcode recognition and operand field split for the four handled operations.
// Purely combinational; fed straight from instr_word, ahead of the execute block's fetch register.
`timescale 1ns/1ps

module lit_file_decode (
  // Program word
  input  wire logic [lit_file_ops_pkg::WORD_W-1:0] word,
  // Decoded fields
  output lit_file_ops_pkg::op_e                    op,
  output logic                                     dest,
  output logic [lit_file_ops_pkg::ADDR_W-1:0]      addr,
  output logic [lit_file_ops_pkg::DATA_W-1:0]      lit
);

  logic [5:0] opc6;  // Upper six opcode bits
  logic [3:0] opc4;  // Upper four opcode bits

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction and pattern match
  always_comb begin
    opc6 = word[lit_file_ops_pkg::OPC_MSB:lit_file_ops_pkg::OPC6_LSB];
    opc4 = word[lit_file_ops_pkg::OPC_MSB:lit_file_ops_pkg::OPC4_LSB];
    dest = word[lit_file_ops_pkg::DEST_BIT];
    addr = word[lit_file_ops_pkg::ADDR_MSB:lit_file_ops_pkg::ADDR_LSB];
    lit  = word[lit_file_ops_pkg::LIT_MSB:lit_file_ops_pkg::LIT_LSB];
    if (opc6 == lit_file_ops_pkg::PAT_OR_LIT) begin
      op = lit_file_ops_pkg::OP_OR_LITERAL_INTO;
    end else if (opc6 == lit_file_ops_pkg::PAT_OR_FILE) begin
      op = lit_file_ops_pkg::OP_OR_ACC_WITH_FILE;
    end else if (opc6 == lit_file_ops_pkg::PAT_COPY_FILE) begin
      op = lit_file_ops_pkg::OP_COPY_FILE_VALUE;
    end else if (opc4 == lit_file_ops_pkg::PAT_LOAD_LIT) begin
      op = lit_file_ops_pkg::OP_LOAD_LITERAL_ACC;
    end else begin
      op = lit_file_ops_pkg::OP_NONE;
    end
  end

endmodule : lit_file_decode

/* verif/lit_file_exec_properties.sv */
// Port checker for the literal/file execute block.
// Assumes a register file that reads combinationally at file_raddr.
`timescale 1ns/1ps
module lit_file_exec_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  // Watched ports
  input wire logic        instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic [6:0]  file_raddr,
  input wire logic [7:0]  file_rdata,
  input wire logic        file_we,
  input wire logic [6:0]  file_waddr,
  input wire logic [7:0]  file_wdata,
  input wire logic [7:0]  acc,
  input wire logic        zero_flag,
  input wire logic        exec_done
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Decoded requests
  wire or_l = instr_valid && instr_word[13:8] == 6'h38;
  wire or_f = instr_valid && instr_word[13:8] == 6'h04;
  wire cp_f = instr_valid && instr_word[13:8] == 6'h08;
  wire ld_l = instr_valid && instr_word[13:10] == 4'hc;
  wire d    = instr_word[7];
  // File operand per the register file contract: a write still shown on
  // file_we lands only at the next edge, so its data is the live value
  wire [7:0] fv = (file_we && file_waddr == file_raddr) ? file_wdata : file_rdata;
  // Word taken at one edge, results shown after the next one
  AST_OR_LIT: assert property (or_l |-> ##2
    acc == ($past(acc) | $past(instr_word[7:0], 2)) && zero_flag == (acc == 8'h00)) else $error("or-literal");
  AST_OR_FILE_ACC: assert property (or_f && !d |-> ##2
    acc == ($past(acc) | $past(fv)) && zero_flag == (acc == 8'h00) && !file_we) else $error("or-file to acc");
  AST_OR_FILE_REG: assert property (or_f && d |-> ##2 file_we && $stable(acc) &&
    file_wdata == ($past(acc) | $past(fv)) && zero_flag == (file_wdata == 8'h00)) else $error("or-file to reg");
  AST_COPY_ACC: assert property (cp_f && !d |-> ##2
    acc == $past(fv) && zero_flag == (acc == 8'h00) && !file_we) else $error("copy to acc");
  AST_COPY_REG: assert property (cp_f && d |-> ##2 file_we && $stable(acc) &&
    file_wdata == $past(fv) && zero_flag == (file_wdata == 8'h00)) else $error("copy to reg");
  AST_LOAD: assert property (ld_l |-> ##2
    acc == $past(instr_word[7:0], 2) && $stable(zero_flag) && !file_we) else $error("load literal");
  AST_ADDR: assert property ((or_f || cp_f) |-> ##1 file_raddr == $past(instr_word[6:0])
    ##1 (file_we == $past(d, 2)) && (!file_we || file_waddr == $past(file_raddr))) else $error("file address");
  AST_DONE: assert property ((or_l || or_f || cp_f || ld_l) |-> ##2 exec_done) else $error("no done");
  AST_IDLE: assert property (!(or_l || or_f || cp_f || ld_l) |-> ##2
    !exec_done && !file_we && $stable(acc)) else $error("stray op");
endmodule : lit_file_exec_checker

bind lit_file_exec lit_file_exec_checker i_chk (.mclk, .sys_rst, .instr_valid, .instr_word, .file_raddr,
  .file_rdata, .file_we, .file_waddr, .file_wdata, .acc, .zero_flag, .exec_done);

/* verif/tb_top.sv */
// Self-checking bench for the literal/file execute block.
// Holds a simple register file that writes on edges with file_we high.
`timescale 1ns/1ps
module tb_top;
  logic        mclk        = 1'b0;
  logic        sys_rst     = 1'b1;
  logic        instr_valid = 1'b0;
  logic [13:0] instr_word  = 14'h0000;
  logic [6:0]  file_raddr, file_waddr;
  logic [7:0]  file_wdata, acc, mem [128];
  logic        file_we, zero_flag, exec_done;
  int          mismatches = 0, n_checks = 0, n_done = 0;
  wire  [7:0]  file_rdata = mem[file_raddr];

  always #5 mclk = ~mclk;
  // Register file write and completion count
  always @(posedge mclk) begin
    if (file_we) mem[file_waddr] <= file_wdata;
    if (exec_done) n_done <= n_done + 1;
  end

  lit_file_exec i_dut (.mclk, .sys_rst, .instr_valid, .instr_word, .file_raddr, .file_rdata,
    .file_we, .file_waddr, .file_wdata, .acc, .zero_flag, .exec_done);

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One word through the pipe, then the write is let land
  task automatic run(input logic [13:0] w, input logic done);
    @(posedge mclk) #1;
    instr_valid = 1'b1;
    instr_word  = w;
    @(posedge mclk) #1;
    instr_valid = 1'b0;
    @(posedge mclk);
    #1 chk({7'h00, exec_done}, {7'h00, done});
    @(posedge mclk) #1;
    chk({7'h00, exec_done}, 8'h00);
  endtask : run

  task automatic t_literal;
    run(14'h3000, 1'b1);
    run(14'h3800, 1'b1);
    chk(acc, 8'h00);
    chk({7'h00, zero_flag}, 8'h01);
    for (int m = 0; m < 4; m++) begin
      run({4'hc, m[1:0], 6'h26, m[1:0]}, 1'b1);
      chk(acc, {6'h26, m[1:0]});
      chk({7'h00, zero_flag}, 8'h01);
    end
    run(14'h3835, 1'b1);
    chk(acc, 8'hbf);
    chk({7'h00, zero_flag}, 8'h00);
    $display("t_literal done");
  endtask : t_literal

  task automatic t_file;
    run(14'h3091, 1'b1);
    run(14'h0405, 1'b1);
    chk(acc, 8'h93);
    run(14'h0486, 1'b1);
    chk(mem[6], 8'hd3);
    chk(acc, 8'h93);
    run(14'h0803, 1'b1);
    chk(acc, 8'h00);
    chk({7'h00, zero_flag}, 8'h01);
    run(14'h3077, 1'b1);
    run(14'h0887, 1'b1);
    chk(mem[7], 8'h87);
    chk(acc, 8'h77);
    chk({7'h00, zero_flag}, 8'h00);
    run(14'h3000, 1'b1);
    run(14'h0403, 1'b1);
    chk({7'h00, zero_flag}, 8'h01);
    $display("t_file done");
  endtask : t_file

  // Back-to-back words, last one unrecognised
  task automatic t_pipe;
    int n;
    n = n_done;
    @(posedge mclk) #1;
    instr_valid = 1'b1;
    instr_word = 14'h3001;
    @(posedge mclk) #1;
    instr_word = 14'h3802;
    @(posedge mclk) #1;
    instr_word = 14'h3804;
    @(posedge mclk) #1;
    instr_word = 14'h0000;
    @(posedge mclk) #1;
    instr_valid = 1'b0;
    repeat (4) @(posedge mclk);
    #1 chk(acc, 8'h07);
    chk(8'(n_done - n), 8'h03);
    $display("t_pipe done");
  endtask : t_pipe

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  initial begin
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'h80;
    mem[3] = 8'h00;
    mem[5] = 8'h13;
    mem[6] = 8'h40;
    repeat (12) @(posedge mclk);
    #1 sys_rst = 1'b0;
    chk(acc, 8'h00);
    t_literal();
    t_file();
    t_pipe();
    end_of_test();
  end

  // Watchdog
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
endmodule : tb_top
